// [hw/dsf_top.sv]
// dynamic per-interval functions: delay, rate, limiter, average, timer
// How it works
// R1 - program never mixes buffer operations in one step
// R2 - rate output is current minus delayed input
// R3 - dead time 1.000 is 1000 s, max 2047
// R4 - rate result is signed, may be negative
// R5 - each dynamic operation runs once per interval
// R6 - limiter: input third, up second, down top
// R7 - limit 0.001..6.999, below minimum acts as minimum
// R8 - limit 7.000 or more passes input unlimited
// R9 - average is mean of used buffered samples
// R10 - average time 1 s resolution, max 2047
// R11 - sample period at least one interval, partial depth
// R12 - start below 0.5 clears timer, outputs zero
// R13 - start at 0.5 counts, 1.000 = 1000 s
// R14 - timer wraps to zero at 4095999 seconds
// R15 - timer reads and overwrites stack top
// R16 - delay output is input one dead time earlier
// R17 - 40 entries, filled at start, shift every time/40
// R18 - limiter step per interval from percent per minute
// R19 - timer advances one interval per started execution
`timescale 1ns/1ps
`default_nettype none

module dsf_top #(
    parameter int W           = dsf_pkg::DSF_W,
    parameter int DEPTH       = dsf_pkg::DSF_DEPTH,
    parameter int INTERVAL_MS = dsf_pkg::DSF_INTERVAL_MS
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 op_valid_in,
    input  wire dsf_pkg::dsf_op_t     op_code_in,
    input  wire logic signed [W-1:0]  stack_top_in,
    input  wire logic signed [W-1:0]  stack_second_in,
    input  wire logic signed [W-1:0]  stack_third_in,
    output logic                      result_valid_out,
    output logic signed [W-1:0]       stack_top_out
);
    localparam int  IW = $clog2(DEPTH) + 1;
    localparam int  SW = W + $clog2(DEPTH) + 1;
    localparam int  LW = W + dsf_pkg::DSF_FRAC;
    localparam longint IMS = longint'(INTERVAL_MS);

    generate
        if (INTERVAL_MS < 1 || W < 24 || W > 48) begin : g_bad_cfg
            $error("dsf_top: interval or width out of range");
        end
    endgenerate

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic                 buf_primed_reg;
    logic [31:0]          phase_reg;
    logic                 lim_primed_reg;
    logic signed [LW-1:0] lim_reg;
    logic [15:0]          tim_ms_reg;
    logic [31:0]          tim_sec_reg;
    logic                 valid_reg;
    logic signed [W-1:0]  top_reg;

    // ---------------------------------------------------------------
    // shared sample buffer: delay, rate of change, moving average
    // ---------------------------------------------------------------
    logic                  is_buf_op;
    logic                  buf_fill;
    logic                  buf_shift;
    logic signed [63:0]    t_sec;
    logic [63:0]           t_ms;
    logic [63:0]           n_raw;
    logic [63:0]           per_raw;
    logic [IW-1:0]         used;
    logic [31:0]           period;
    logic signed [W-1:0]   oldest;
    logic signed [W-1:0]   younger;
    logic signed [SW-1:0]  sum;
    logic signed [63:0]    delayed;
    logic signed [63:0]    average;

    assign is_buf_op = op_valid_in &&
                       (op_code_in == dsf_pkg::DSF_OP_DEAD_TIME_DELAY ||
                        op_code_in == dsf_pkg::DSF_OP_RATE_OF_CHANGE  ||
                        op_code_in == dsf_pkg::DSF_OP_MOVING_AVERAGE);

    // time setting in seconds, clamped to the legal range
    always_comb begin
        t_sec = 64'(stack_top_in);                            // R3 R10
        if (t_sec < 0) begin
            t_sec = '0;
        end else if (t_sec > dsf_pkg::DSF_DT_MAX) begin
            t_sec = dsf_pkg::DSF_DT_MAX;
        end
        t_ms    = 64'(t_sec) * dsf_pkg::DSF_MS_PER_S;
        n_raw   = t_ms / 64'(IMS);                            // R11
        per_raw = t_ms / 64'(longint'(DEPTH) * IMS);          // R17
        if (n_raw >= 64'(DEPTH)) begin
            used = IW'(DEPTH);
        end else if (n_raw < 64'd1) begin
            used = IW'(1);
        end else begin
            used = n_raw[IW-1:0];
        end
        period = (per_raw < 64'd1) ? 32'd1 : per_raw[31:0];   // R11
    end

    // first call fills, later calls shift once a period has passed
    assign buf_fill  = is_buf_op && !buf_primed_reg;           // R17
    assign buf_shift = is_buf_op && buf_primed_reg && (phase_reg + 32'd1 >= period);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            buf_primed_reg <= 1'b0;
            phase_reg      <= '0;
        end else if (buf_fill) begin
            buf_primed_reg <= 1'b1;
            phase_reg      <= '0;
        end else if (buf_shift) begin
            phase_reg      <= '0;
        end else if (is_buf_op) begin
            phase_reg      <= phase_reg + 32'd1;
        end
    end

    dsf_sample_buffer #(
        .W     (W),
        .DEPTH (DEPTH)
    ) u_buffer (
        .clk_in      (core_clk_in),
        .resetn_in   (resetn_in),
        .fill_in     (buf_fill),
        .shift_in    (buf_shift),
        .sample_in   (stack_second_in),
        .used_in     (used),
        .oldest_out  (oldest),
        .younger_out (younger),
        .sum_out     (sum)
    );

    // linear interpolation between the two outgoing samples
    always_comb begin
        if (!buf_primed_reg) begin
            delayed = 64'(stack_second_in);
            average = 64'(stack_second_in);
        end else begin
            // signed casts keep the division signed; a negative sum must not go unsigned
            delayed = 64'(oldest) +
                      ((64'(younger) - 64'(oldest)) * longint'(phase_reg)) /
                      longint'(period);                                           // R16
            average = 64'(sum) / longint'(used);                                  // R9
        end
    end

    // ---------------------------------------------------------------
    // rate limiter: fractional state so slow rates still move
    // ---------------------------------------------------------------
    logic signed [63:0]   up_rate;
    logic signed [63:0]   dn_rate;
    logic signed [63:0]   up_step;
    logic signed [63:0]   dn_step;
    logic signed [63:0]   x_q;
    logic signed [63:0]   diff;
    logic signed [63:0]   lim_next;

    always_comb begin
        up_rate = 64'(stack_second_in);                             // R6
        dn_rate = 64'(stack_top_in);                                // R6
        if (up_rate < dsf_pkg::DSF_RATE_MIN) up_rate = dsf_pkg::DSF_RATE_MIN; // R7
        if (dn_rate < dsf_pkg::DSF_RATE_MIN) dn_rate = dsf_pkg::DSF_RATE_MIN; // R7
        up_step  = (up_rate * IMS <<< dsf_pkg::DSF_FRAC) / dsf_pkg::DSF_MS_PER_MIN; // R18
        dn_step  = (dn_rate * IMS <<< dsf_pkg::DSF_FRAC) / dsf_pkg::DSF_MS_PER_MIN; // R18
        x_q      = 64'(stack_third_in) <<< dsf_pkg::DSF_FRAC;       // R6
        diff     = x_q - 64'(lim_reg);
        lim_next = x_q;
        if (lim_primed_reg) begin
            if (diff > 0 && up_rate < dsf_pkg::DSF_RATE_OPEN && diff > up_step) begin // R8
                lim_next = 64'(lim_reg) + up_step;                  // R18
            end else if (diff < 0 && dn_rate < dsf_pkg::DSF_RATE_OPEN && -diff > dn_step) begin
                lim_next = 64'(lim_reg) - dn_step;                  // R18
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lim_primed_reg <= 1'b0;
            lim_reg        <= '0;
        end else if (op_valid_in && op_code_in == dsf_pkg::DSF_OP_RATE_LIMITER) begin
            lim_primed_reg <= 1'b1;
            lim_reg        <= lim_next[LW-1:0];
        end
    end

    // ---------------------------------------------------------------
    // elapsed timer: milliseconds carry into whole seconds
    // ---------------------------------------------------------------
    logic               tim_run;
    logic [31:0]        ms_sum;
    logic [31:0]        ms_next;
    logic [31:0]        sec_next;

    assign tim_run = 64'(stack_top_in) >= dsf_pkg::DSF_HALF;         // R13 R15

    always_comb begin
        ms_sum   = 32'(tim_ms_reg) + 32'(INTERVAL_MS);               // R19
        ms_next  = ms_sum % 32'(dsf_pkg::DSF_MS_PER_S);
        sec_next = tim_sec_reg + ms_sum / 32'(dsf_pkg::DSF_MS_PER_S);
        if (64'(sec_next) >= dsf_pkg::DSF_TIMER_WRAP) begin
            sec_next = '0;                                           // R14
        end
        if (!tim_run) begin
            ms_next  = '0;                                           // R12
            sec_next = '0;                                           // R12
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tim_ms_reg  <= '0;
            tim_sec_reg <= '0;
        end else if (op_valid_in && op_code_in == dsf_pkg::DSF_OP_ELAPSED_TIMER) begin
            tim_ms_reg  <= ms_next[15:0];
            tim_sec_reg <= sec_next;
        end
    end

    // ---------------------------------------------------------------
    // result register: new stack top one cycle after the request
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            valid_reg <= 1'b0;
            top_reg   <= '0;
        end else begin
            valid_reg <= op_valid_in;
            if (op_valid_in) begin
                case (op_code_in)
                    dsf_pkg::DSF_OP_DEAD_TIME_DELAY: top_reg <= delayed[W-1:0];      // R16
                    dsf_pkg::DSF_OP_RATE_OF_CHANGE:                                   // R2 R4
                        top_reg <= W'(64'(stack_second_in) - delayed);
                    dsf_pkg::DSF_OP_MOVING_AVERAGE:  top_reg <= average[W-1:0];      // R9
                    dsf_pkg::DSF_OP_RATE_LIMITER:                                     // R6
                        top_reg <= W'(lim_next >>> dsf_pkg::DSF_FRAC);
                    dsf_pkg::DSF_OP_ELAPSED_TIMER:   top_reg <= W'(sec_next);         // R13 R15
                    default:                         top_reg <= stack_top_in;
                endcase
            end
        end
    end

    assign result_valid_out = valid_reg;
    assign stack_top_out    = top_reg;

    // ---------------------------------------------------------------
    // assertions and covers
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    logic is_tim;
    logic is_lim;
    assign is_tim = op_valid_in && op_code_in == dsf_pkg::DSF_OP_ELAPSED_TIMER;
    assign is_lim = op_valid_in && op_code_in == dsf_pkg::DSF_OP_RATE_LIMITER;

    a_timer_clear_zero: assert property (is_tim && !tim_run |=> stack_top_out == '0) // R12
        else $error("timer did not clear on low start");
    a_timer_wrap_bound: assert property (64'(tim_sec_reg) < dsf_pkg::DSF_TIMER_WRAP) // R14
        else $error("timer passed wrap point");
    a_timer_step_ms: assert property (is_tim && tim_run && tim_sec_reg < 32'd1000 |=> // R19
        64'(tim_sec_reg) * 1000 + 64'(tim_ms_reg) ==
        64'($past(tim_sec_reg)) * 1000 + 64'($past(tim_ms_reg)) + IMS)
        else $error("timer did not advance one interval");
    a_timer_out_sec: assert property (is_tim |=> stack_top_out == W'(tim_sec_reg)) // R13
        else $error("timer output differs from count");
    a_lim_first_pass: assert property (is_lim && !lim_primed_reg |=>               // R6
        stack_top_out == $past(stack_third_in))
        else $error("limiter first result not input");
    a_lim_open_pass: assert property (is_lim && lim_primed_reg &&                   // R8
        64'(stack_second_in) >= dsf_pkg::DSF_RATE_OPEN &&
        64'(stack_top_in) >= dsf_pkg::DSF_RATE_OPEN |=> stack_top_out == $past(stack_third_in))
        else $error("open limit did not pass input");
    a_lim_rise_bound: assert property (is_lim && lim_primed_reg &&                  // R18
        64'(stack_third_in) > 64'(lim_reg >>> dsf_pkg::DSF_FRAC) |=>
        stack_top_out <= $past(stack_third_in))
        else $error("limiter overshot rising input");
    a_buf_fill_once: assert property (is_buf_op && !buf_primed_reg |=>             // R17
        buf_primed_reg && phase_reg == '0)
        else $error("buffer not primed by first call");
    a_phase_bound: assert property (is_buf_op && buf_primed_reg |->                // R11
        phase_reg < period || !buf_shift)
        else $error("sample phase past period");
    a_avg_first_input: assert property (is_buf_op && !buf_primed_reg &&            // R9
        op_code_in == dsf_pkg::DSF_OP_MOVING_AVERAGE |=> stack_top_out == $past(stack_second_in))
        else $error("first average not the input");
    a_roc_first_zero: assert property (is_buf_op && !buf_primed_reg &&             // R2
        op_code_in == dsf_pkg::DSF_OP_RATE_OF_CHANGE |=> stack_top_out == '0)
        else $error("first rate of change not zero");
    a_result_timing: assert property (op_valid_in |=> result_valid_out ##1         // R15
        (result_valid_out == $past(op_valid_in)))
        else $error("result strobe misaligned");

    c_timer_runs:  cover property (is_tim && tim_run ##1 is_tim && tim_run);
    c_buf_shift:   cover property (buf_shift);
    c_lim_limited: cover property (is_lim && lim_primed_reg && diff > up_step);
    c_roc_neg:     cover property (valid_reg && top_reg < 0);
endmodule // dsf_top

`default_nettype wire

// [hw/dsf_sample_buffer.sv]
// package and shared sample buffer of the dynamic signal functions
`timescale 1ns/1ps
`default_nettype none

package dsf_pkg;
    // ---------------------------------------------------------------
    // scaling and timing constants
    // ---------------------------------------------------------------
    localparam int     DSF_W           = 32;        // operand width, 1.000 = 1000
    localparam int     DSF_DEPTH       = 40;        // buffer entries
    localparam int     DSF_INTERVAL_MS = 100;       // computation interval
    localparam longint DSF_HALF        = 64'd500;   // 0.5 start threshold
    localparam longint DSF_DT_MAX      = 64'd2047000; // internal 2047.000
    localparam longint DSF_MS_PER_S    = 64'd1000;
    localparam longint DSF_MS_PER_MIN  = 64'd60000;
    localparam longint DSF_RATE_MIN    = 64'd1;     // 0.001 = 0.1 %/min
    localparam longint DSF_RATE_OPEN   = 64'd7000;  // 7.000 = 700 %/min
    localparam int     DSF_FRAC        = 16;        // limiter fraction bits
    localparam longint DSF_TIMER_WRAP  = 64'd4095999; // seconds
    // operation codes presented with each request
    typedef enum logic [2:0] {
        DSF_OP_DEAD_TIME_DELAY,
        DSF_OP_RATE_OF_CHANGE,
        DSF_OP_MOVING_AVERAGE,
        DSF_OP_RATE_LIMITER,
        DSF_OP_ELAPSED_TIMER
    } dsf_op_t;
endpackage

module dsf_sample_buffer #(
    parameter int W     = 32,
    parameter int DEPTH = 40
) (
    input  wire logic                            clk_in,
    input  wire logic                            resetn_in,
    input  wire logic                            fill_in,
    input  wire logic                            shift_in,
    input  wire logic signed [W-1:0]             sample_in,
    input  wire logic [$clog2(DEPTH):0]          used_in,
    output logic signed [W-1:0]                  oldest_out,
    output logic signed [W-1:0]                  younger_out,
    output logic signed [W+$clog2(DEPTH):0]      sum_out
);
    localparam int SW = W + $clog2(DEPTH) + 1;

    logic signed [W-1:0] entry_reg [DEPTH];

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("dsf_sample_buffer needs at least two entries");
        end
    endgenerate

    // ---------------------------------------------------------------
    // entry 0 is newest; fill loads every entry with one sample
    // ---------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                entry_reg[i] <= '0;
            end else if (fill_in) begin
                entry_reg[i] <= sample_in;   // R17
            end else if (shift_in) begin
                entry_reg[i] <= (i == 0) ? sample_in : entry_reg[(i == 0) ? 0 : i - 1]; // R17
            end
        end
    end

    // taps at the used depth; short settings use fewer entries
    always_comb begin
        oldest_out  = entry_reg[0];
        younger_out = sample_in;
        sum_out     = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (i == int'(used_in) - 1) begin
                oldest_out = entry_reg[i];       // R11
            end
            if (i == int'(used_in) - 2) begin
                younger_out = entry_reg[i];
            end
            if (i < int'(used_in)) begin
                sum_out = sum_out + SW'(entry_reg[i]);   // R9
            end
        end
    end
endmodule // dsf_sample_buffer

`default_nettype wire

// [dv/dsf_program_model.sv]
// program model that hands the block one operation request per computation interval
`timescale 1ns/1ps
`default_nettype none

module dsf_program_model (
    input  wire logic                clk_in,
    input  wire logic                go_in,
    input  wire dsf_pkg::dsf_op_t    op_in,
    input  wire logic signed [31:0]  top_in,
    input  wire logic signed [31:0]  second_in,
    input  wire logic signed [31:0]  third_in,
    output logic                     valid_out,
    output dsf_pkg::dsf_op_t         op_out,
    output logic signed [31:0]       top_out,
    output logic signed [31:0]       second_out,
    output logic signed [31:0]       third_out
);
    // -------------------------------------------------------------------
    // idle operand pattern
    // -------------------------------------------------------------------
    // idle stack words flip every cycle, so a stale operand never looks valid
    logic signed [31:0] junk_reg = 32'h5a5a_c3c3;
    always @(posedge clk_in) begin
        junk_reg <= ~junk_reg;
    end

    // -------------------------------------------------------------------
    // request drive
    // -------------------------------------------------------------------
    // one strobe per program call; each call stands for one whole interval
    assign valid_out  = go_in;
    // the caller never stacks two buffer operations into one step
    assign op_out     = op_in;
    assign top_out    = go_in ? top_in : junk_reg;
    assign second_out = go_in ? second_in : ~junk_reg;
    assign third_out  = go_in ? third_in : junk_reg;
endmodule // dsf_program_model

`default_nettype wire

// [dv/test_dynamic_signal_functions.sv]
// self-checking bench of the dynamic signal functions block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD %0t got %h want %h", $time, got, exp); end end

module test_dynamic_signal_functions;
    logic               core_clk = 1'b0;
    logic               resetn   = 1'b0;
    logic               go       = 1'b0;
    dsf_pkg::dsf_op_t   op_sel   = dsf_pkg::DSF_OP_ELAPSED_TIMER;
    logic signed [31:0] top_v    = 32'h0000_0000;
    logic signed [31:0] sec_v    = 32'h0000_0000;
    logic signed [31:0] thr_v    = 32'h0000_0000;
    logic               p_valid, result_valid;
    dsf_pkg::dsf_op_t   p_op;
    logic signed [31:0] p_top, p_sec, p_thr, stack_top;
    int                 error_cnt = 0;
    int                 checked   = 0;
    logic [15:0]        lfsr;
    longint             tim_ms, lim_state, e[40];
    bit                 lim_primed, buf_primed;

    // 250 MHz core clock
    always #2 core_clk = ~core_clk;

    dsf_program_model prog (.clk_in(core_clk), .go_in(go), .op_in(op_sel), .top_in(top_v),
        .second_in(sec_v), .third_in(thr_v), .valid_out(p_valid), .op_out(p_op),
        .top_out(p_top), .second_out(p_sec), .third_out(p_thr));
    dsf_top dut (.core_clk_in(core_clk), .resetn_in(resetn), .op_valid_in(p_valid),
        .op_code_in(p_op), .stack_top_in(p_top), .stack_second_in(p_sec),
        .stack_third_in(p_thr), .result_valid_out(result_valid), .stack_top_out(stack_top));

    // -------------------------------------------------------------------
    // stimulus source and reference functions
    // -------------------------------------------------------------------
    function logic [15:0] rnd();
        lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hb400 : 16'h0000);
        return lfsr;
    endfunction
    // timer keeps milliseconds, answers in whole seconds
    function longint exp_timer(longint top);
        if (top < dsf_pkg::DSF_HALF) begin
            tim_ms = 0;
            return 0;
        end
        tim_ms += dsf_pkg::DSF_INTERVAL_MS;
        if (tim_ms / dsf_pkg::DSF_MS_PER_S >= dsf_pkg::DSF_TIMER_WRAP) tim_ms = 0;
        return tim_ms / dsf_pkg::DSF_MS_PER_S;
    endfunction
    function longint lim_step(longint r);
        if (r < dsf_pkg::DSF_RATE_MIN) r = dsf_pkg::DSF_RATE_MIN;
        return r * dsf_pkg::DSF_INTERVAL_MS * 64'h0001_0000 / dsf_pkg::DSF_MS_PER_MIN;
    endfunction
    // limiter state in 1/65536 units; an open limit jumps straight to the input
    function longint exp_limit(longint x, longint up, longint dn);
        longint tgt;
        tgt = x * 64'h0001_0000;
        if (!lim_primed || (tgt > lim_state && up >= dsf_pkg::DSF_RATE_OPEN)
            || (tgt < lim_state && dn >= dsf_pkg::DSF_RATE_OPEN)) lim_state = tgt;
        else if (tgt > lim_state)
            lim_state = (lim_state + lim_step(up) < tgt) ? lim_state + lim_step(up) : tgt;
        else if (tgt < lim_state)
            lim_state = (lim_state - lim_step(dn) > tgt) ? lim_state - lim_step(dn) : tgt;
        lim_primed = 1'b1;
        return lim_state >>> 16;
    endfunction
    // times below 8 s keep the sampling period at one call, so no interpolation
    function longint exp_buf(dsf_pkg::dsf_op_t op, longint t, longint x);
        longint used, sum, dly;
        used = t * dsf_pkg::DSF_MS_PER_S / dsf_pkg::DSF_INTERVAL_MS;
        used = (used < 1) ? 1 : (used > dsf_pkg::DSF_DEPTH) ? dsf_pkg::DSF_DEPTH : used;
        sum = 0;
        if (!buf_primed) begin
            foreach (e[i]) e[i] = x;
            buf_primed = 1'b1;
        end
        dly = e[used-1];
        for (int i = 0; i < used; i++) sum += e[i];
        for (int i = 39; i > 0; i--) e[i] = e[i-1];
        e[0] = x;
        if (op == dsf_pkg::DSF_OP_RATE_OF_CHANGE) return x - dly;
        if (op == dsf_pkg::DSF_OP_MOVING_AVERAGE) return sum / used;
        return dly;
    endfunction

    // -------------------------------------------------------------------
    // drivers and verdict
    // -------------------------------------------------------------------
    // one request, then the answer one cycle later; the pulse must be gone before
    task automatic run_op(input dsf_pkg::dsf_op_t op, input longint top, input longint sec,
                          input longint thr, input longint exp_val);
        @(posedge core_clk);
        #1;
        `CHK(result_valid, 1'b0)
        go = 1'b1;
        op_sel = op;
        top_v = top[31:0];
        sec_v = sec[31:0];
        thr_v = thr[31:0];
        @(posedge core_clk);
        #1;
        go = 1'b0;
        `CHK(result_valid, 1'b1)
        `CHK(stack_top, exp_val[31:0])
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        #1;
        resetn = 1'b0;
        tim_ms = 0;
        lim_primed = 1'b0;
        buf_primed = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        resetn = 1'b1;
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        longint a, b, c, t, x;
        logic [15:0] r;
        dsf_pkg::dsf_op_t o;
        lfsr = 16'h4383;
        do_reset();
        for (int k = 0; k < 25; k++) run_op(dsf_pkg::DSF_OP_ELAPSED_TIMER, 64'h01f4, 0, 0, exp_timer(64'h01f4));
        run_op(dsf_pkg::DSF_OP_ELAPSED_TIMER, 64'h01f3, 0, 0, exp_timer(64'h01f3));
        for (int k = 0; k < 60; k++) begin
            r = rnd();
            a = (r[3:0] == 4'h0) ? 64'h0100 : 64'h01f4 + r[15:8];
            run_op(dsf_pkg::DSF_OP_ELAPSED_TIMER, a, rnd(), rnd(), exp_timer(a));
        end
        run_op(dsf_pkg::DSF_OP_RATE_LIMITER, 64'h0001, 64'h0003, 64'h0000, exp_limit(0, 3, 1));
        run_op(dsf_pkg::DSF_OP_RATE_LIMITER, 64'h0000, 64'h03e8, 64'h03e8, exp_limit(1000, 1000, 0));
        for (int k = 0; k < 90; k++) begin
            r = rnd();
            x = r[10:0];
            a = (r[13:11] > 3'h5) ? rnd() : (r[13:11] == 3'h0) ? 0 : (r[13:11] == 3'h1) ? 1 :
                (r[13:11] == 3'h2) ? 64'h03e8 : (r[13:11] == 3'h3) ? 64'h1b57 : 64'h1b58;
            b = rnd();
            b = b[0] ? 64'h1b58 : b[1] ? b[15:5] : 0;
            run_op(dsf_pkg::DSF_OP_RATE_LIMITER, b, a, x, exp_limit(x, a, b));
        end
        for (int k = 0; k < 150; k++) begin
            r = rnd();
            t = r[2:0];
            x = longint'(r[15:5]) - 64'h0400;
            c = r[4:3];
            o = dsf_pkg::dsf_op_t'((c == 0) ? dsf_pkg::DSF_OP_DEAD_TIME_DELAY :
                (c == 1) ? dsf_pkg::DSF_OP_RATE_OF_CHANGE : dsf_pkg::DSF_OP_MOVING_AVERAGE);
            run_op(o, t, x, rnd(), exp_buf(o, t, x));
        end
        // a reset mid-run must clear timer count and the buffer fill
        do_reset();
        for (int k = 0; k < 10; k++) run_op(dsf_pkg::DSF_OP_ELAPSED_TIMER, 64'h0258, 0, 0, exp_timer(64'h0258));
        run_op(dsf_pkg::DSF_OP_DEAD_TIME_DELAY, 64'h7fff_ffff, 64'h0123, 0, 64'h0123);
        run_op(dsf_pkg::DSF_OP_RATE_OF_CHANGE, 64'h001f_3c19, 64'h0050, 0, 64'h0050 - 64'h0123);
        run_op(dsf_pkg::DSF_OP_MOVING_AVERAGE, 64'h001f_3c18, 64'h07ff, 0, 64'h0123);
        give_verdict();
    end

    // watchdog: the sequence needs roughly 700 cycles
    initial begin
        #80000;
        error_cnt++;
        give_verdict();
    end
endmodule // test_dynamic_signal_functions

`default_nettype wire
